//--- logic/port_e_pkg.sv
// Constants shared by the general-purpose port block
package port_e_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_PIN_DATA = 4'h0;
  localparam logic [3:0] OFS_LATCH    = 4'h4;
  localparam logic [3:0] OFS_DIR      = 4'h8;

  // ----------------------------------------------------------------------
  // Field positions and bidirectional pin count
  // ----------------------------------------------------------------------
  localparam int BIT_IBF      = 7;
  localparam int BIT_OBF      = 6;
  localparam int BIT_INPUT_OVERFLOW_FLAG     = 5;
  localparam int BIT_MODE     = 4;
  localparam int BIT_PIN3     = 3;
  localparam int NUM_BIDIR    = 3;

  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] DIR_RESET       = 3'h7;
  localparam logic [2:0] LATCH_RESET     = 3'h0;
  localparam logic [3:0] PCFG_DIGITAL_LO = 4'hA;
  localparam logic [3:0] PCFG_DIGITAL_HI = 4'hF;

endpackage : port_e_pkg

//--- logic/port_e_gpio.sv
// General-purpose port with direction control, slave port status and a Wishbone slave
// Notes on behaviour
// RULE_01: Large package gives four pins, three bidirectional with own direction bits.
// RULE_02: Bidirectional pin selected analog reads back as zero.
// RULE_03: Direction 1 releases the driver; direction 0 drives the latch onto the pin.
// RULE_04: Direction bits drive output enables even while a pin is analog.
// RULE_05: After power-on the three bidirectional pins come up as analog inputs.
// RULE_06: Latch register is mapped; reads return latch, not pin levels.
// RULE_07: Fourth pin input only; digital when clear-enable is 0, else master clear.
// RULE_08: Data bit for pin three exists only when master clear is disabled.
// RULE_09: Small package keeps only the input-only pin, and only with clear disabled.
// RULE_10: Direction bits in 2..0; bit 3 reads zero.
// RULE_11: After reset bits 7..4 read 0 and direction bits read 1.
// RULE_12: Input-buffer-full flag in bit 7 shows an unread received word.
// RULE_13: Output-buffer-full flag in bit 6 shows an unread written word.
// RULE_14: Overflow flag in bit 5 sets on write to full buffer; software clears.
// RULE_15: Mode bit 4 selects slave port operation when 1.
// RULE_16: Driven latch unaffected by analog; digital input path off while analog.
// RULE_17: In slave mode with inputs, pins 0..2 carry read, write and select strobes.
// RULE_18: Strobes also need the analog config field between 1010 and 1111.
// RULE_19: End of external write sets the slave port interrupt flag and input full.
// RULE_20: Writes to buffer-full flags are ignored; other bits take written values.
// RULE_21: Analog selection per pin comes in from the analog configuration logic.
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module port_e_gpio #(
  parameter bit LARGE_PACKAGE = 1'b1 // see RULE_01
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic [2:0]  pin_in,
  output logic [2:0]       pin_out,
  output logic [2:0]       pin_oe,
  input  wire logic        input_only_pin_3,
  input  wire logic        master_clear_enable_cfg,
  output logic             master_clear_request,
  input  wire logic [2:0]  analog_select, // see RULE_21
  input  wire logic [3:0]  analog_pin_config_field,
  input  wire logic        slave_write_end,
  input  wire logic        slave_read_start,
  input  wire logic        input_buffer_read,
  input  wire logic        output_buffer_write,
  output logic             slave_port_irq_flag,
  output logic             strobe_active,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             chip_select_n
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [2:0]  dir;
  logic [2:0]  latch;
  logic        slave_port_mode_bit;
  logic        input_buffer_full_flag;
  logic        output_buffer_full_flag;
  logic        input_overflow_flag;
  logic [2:0]  next_dir;
  logic [2:0]  next_latch;
  logic        next_mode;
  logic        next_ibf;
  logic        next_obf;
  logic        next_input_overflow_flag;
  logic        next_ack;
  logic [31:0] next_dat;
  logic [2:0]  next_pin_out;
  logic [2:0]  next_pin_oe;
  logic        next_master_clear_input_req;
  logic        next_irq;
  logic        next_strobe_active;
  logic [2:0]  next_strobes_n;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic        bus_req;
  logic        wr_lane0;
  logic [7:0]  dir_view;
  logic [7:0]  pin_view;
  logic [2:0]  digital_in;
  logic        pin3_present;
  logic        pcfg_digital;

  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];

  assign pin3_present = !master_clear_enable_cfg;                                 // see RULE_08
  assign digital_in   = LARGE_PACKAGE ? (pin_in & ~analog_select) : 3'h0;         // see RULE_02
  assign pcfg_digital = (analog_pin_config_field >= port_e_pkg::PCFG_DIGITAL_LO)
                     && (analog_pin_config_field <= port_e_pkg::PCFG_DIGITAL_HI); // see RULE_18

  always_comb begin
    pin_view = 8'h00;
    pin_view[2:0] = digital_in;                                                   // see RULE_16
    pin_view[port_e_pkg::BIT_PIN3] = pin3_present && input_only_pin_3;            // see RULE_09
    dir_view = 8'h00;                                                             // see RULE_10
    if (LARGE_PACKAGE) begin
      dir_view[2:0] = dir;
      dir_view[port_e_pkg::BIT_MODE] = slave_port_mode_bit;
      dir_view[port_e_pkg::BIT_INPUT_OVERFLOW_FLAG] = input_overflow_flag;
      dir_view[port_e_pkg::BIT_OBF]  = output_buffer_full_flag;
      dir_view[port_e_pkg::BIT_IBF]  = input_buffer_full_flag;
    end
  end

  // ----------------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------------
  always_comb begin
    next_dir   = dir;
    next_latch = latch;
    next_mode  = slave_port_mode_bit;
    next_input_overflow_flag  = input_overflow_flag;
    if (wr_lane0 && LARGE_PACKAGE) begin
      if (wb_adr_i == port_e_pkg::OFS_DIR) begin
        next_dir  = wb_dat_i[2:0];                                                // see RULE_20
        next_mode = wb_dat_i[port_e_pkg::BIT_MODE];                               // see RULE_15
        next_input_overflow_flag = wb_dat_i[port_e_pkg::BIT_INPUT_OVERFLOW_FLAG];
      end
      if (wb_adr_i == port_e_pkg::OFS_LATCH) begin
        next_latch = wb_dat_i[2:0];                                               // see RULE_06
      end
    end
    if (slave_write_end && input_buffer_full_flag) begin
      next_input_overflow_flag = 1'b1;                                                           // see RULE_14
    end
    next_ibf = input_buffer_full_flag;
    if (input_buffer_read) begin
      next_ibf = 1'b0;
    end
    if (slave_write_end) begin
      next_ibf = 1'b1;                                                            // see RULE_12
    end
    next_obf = output_buffer_full_flag;
    if (output_buffer_write) begin
      next_obf = 1'b1;
    end
    if (slave_read_start) begin
      next_obf = 1'b0;                                                            // see RULE_13
    end
    next_irq = slave_write_end;                                                   // see RULE_19
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dir                     <= port_e_pkg::DIR_RESET;                           // see RULE_11
      latch                   <= port_e_pkg::LATCH_RESET;
      slave_port_mode_bit     <= 1'b0;
      input_overflow_flag     <= 1'b0;
      input_buffer_full_flag  <= 1'b0;
      output_buffer_full_flag <= 1'b0;
      slave_port_irq_flag     <= 1'b0;
    end else begin
      dir                     <= next_dir;
      latch                   <= next_latch;
      slave_port_mode_bit     <= next_mode;
      input_overflow_flag     <= next_input_overflow_flag;
      input_buffer_full_flag  <= next_ibf;
      output_buffer_full_flag <= next_obf;
      slave_port_irq_flag     <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  always_comb begin
    next_ack = bus_req;
    next_dat = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        port_e_pkg::OFS_PIN_DATA: next_dat = {24'h00_0000, pin_view};
        port_e_pkg::OFS_LATCH:    next_dat = LARGE_PACKAGE ? {29'h0, latch} : 32'h0; // see RULE_06
        port_e_pkg::OFS_DIR:      next_dat = {24'h00_0000, dir_view};
        default:                  next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------------
  // Pins, master clear and strobes
  // ----------------------------------------------------------------------
  always_comb begin
    next_pin_out  = latch;                                                        // see RULE_16
    next_pin_oe   = LARGE_PACKAGE ? ~dir : 3'h0;                                  // see RULE_03
    next_master_clear_input_req = master_clear_enable_cfg && !input_only_pin_3;                 // see RULE_07
    next_strobe_active = LARGE_PACKAGE && slave_port_mode_bit && (&dir) && pcfg_digital;
    next_strobes_n = 3'h7;
    if (next_strobe_active) begin
      next_strobes_n = pin_in;                                                    // see RULE_17
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_out              <= port_e_pkg::LATCH_RESET;
      pin_oe               <= 3'h0;                                               // see RULE_05
      master_clear_request <= 1'b0;
      strobe_active        <= 1'b0;
      read_strobe_n        <= 1'b1;
      write_strobe_n       <= 1'b1;
      chip_select_n        <= 1'b1;
    end else begin
      pin_out              <= next_pin_out;
      pin_oe               <= next_pin_oe;                                        // see RULE_04
      master_clear_request <= next_master_clear_input_req;
      strobe_active        <= next_strobe_active;
      read_strobe_n        <= next_strobes_n[0];
      write_strobe_n       <= next_strobes_n[1];
      chip_select_n        <= next_strobes_n[2];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_write_dir;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == port_e_pkg::OFS_DIR;
  endsequence

  sequence s_read_pin;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == port_e_pkg::OFS_PIN_DATA;
  endsequence

  sequence s_read_dir;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == port_e_pkg::OFS_DIR;
  endsequence

  sequence s_read_latch;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == port_e_pkg::OFS_LATCH;
  endsequence

  sequence s_write_latch;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == port_e_pkg::OFS_LATCH;
  endsequence

  property p_ack_one;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not a single cycle");

  property p_analog_zero;
    s_read_pin ##0 (LARGE_PACKAGE && analog_select[0]) |=> wb_dat_o[0] == 1'b0;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero"); // see RULE_02

  property p_oe_dir;
    s_write_dir ##0 LARGE_PACKAGE |=> ##1 pin_oe == ~$past(wb_dat_i[2:0], 2);
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("output enable not from direction"); // see RULE_03

  property p_pin3_hidden;
    s_read_pin ##0 master_clear_enable_cfg |=> wb_dat_o[port_e_pkg::BIT_PIN3] == 1'b0;
  endproperty
  a_pin3_hidden: assert property (p_pin3_hidden) else $error("pin three bit present"); // see RULE_08

  property p_ibf_set;
    slave_write_end |=> input_buffer_full_flag && slave_port_irq_flag;
  endproperty
  a_ibf_set: assert property (p_ibf_set) else $error("write end did not set flags"); // see RULE_19

  property p_input_overflow_flag_set;
    (slave_write_end && input_buffer_full_flag) |=> input_overflow_flag;
  endproperty
  a_input_overflow_flag_set: assert property (p_input_overflow_flag_set) else $error("overflow not set"); // see RULE_14

  property p_input_overflow_flag_hold;
    input_overflow_flag && !(wr_lane0 && wb_adr_i == port_e_pkg::OFS_DIR) |=> input_overflow_flag;
  endproperty
  a_input_overflow_flag_hold: assert property (p_input_overflow_flag_hold) else $error("overflow cleared without software"); // see RULE_14

  property p_obf_clear;
    slave_read_start |=> !output_buffer_full_flag;
  endproperty
  a_obf_clear: assert property (p_obf_clear) else $error("output full not cleared"); // see RULE_13

  property p_flags_ro;
    s_write_dir ##0 !slave_write_end && !input_buffer_read |=> input_buffer_full_flag == $past(input_buffer_full_flag);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("software changed input full"); // see RULE_20

  property p_strobe_gate;
    strobe_active |-> $past(slave_port_mode_bit) && $past(&dir) && $past(pcfg_digital);
  endproperty
  a_strobe_gate: assert property (p_strobe_gate) else $error("strobes active without config"); // see RULE_18

  property p_master_clear_input;
    (master_clear_enable_cfg && !input_only_pin_3) |=> master_clear_request;
  endproperty
  a_master_clear_input: assert property (p_master_clear_input) else $error("master clear not raised"); // see RULE_07

  property p_read_latch;
    s_read_latch ##0 LARGE_PACKAGE |=> wb_dat_o[2:0] == $past(latch) && wb_dat_o[31:3] == 29'h0;
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("latch read not latch value"); // see RULE_06

  property p_pin_out_latch;
    pin_out == $past(latch);
  endproperty
  a_pin_out_latch: assert property (p_pin_out_latch) else $error("pin output not from latch"); // see RULE_16

  property p_oe_follow;
    pin_oe == (LARGE_PACKAGE ? ~$past(dir) : 3'h0);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("output enable not from direction bits"); // see RULE_04

  property p_strobe_map;
    strobe_active |-> {chip_select_n, write_strobe_n, read_strobe_n} == $past(pin_in);
  endproperty
  a_strobe_map: assert property (p_strobe_map) else $error("strobes not taken from pins"); // see RULE_17

  property p_strobe_idle;
    !strobe_active |-> read_strobe_n && write_strobe_n && chip_select_n;
  endproperty
  a_strobe_idle: assert property (p_strobe_idle) else $error("strobes low while inactive"); // see RULE_17

  property p_dir_upper;
    s_read_dir |=> wb_dat_o[port_e_pkg::BIT_PIN3] == 1'b0 && wb_dat_o[31:8] == 24'h00_0000;
  endproperty
  a_dir_upper: assert property (p_dir_upper) else $error("unimplemented direction bit set"); // see RULE_10

  property p_analog_all;
    s_read_pin |=> (wb_dat_o[2:0] & $past(analog_select)) == 3'h0;
  endproperty
  a_analog_all: assert property (p_analog_all) else $error("analog pin read nonzero"); // see RULE_02

  property p_ibf_clear;
    input_buffer_read && !slave_write_end |=> !input_buffer_full_flag;
  endproperty
  a_ibf_clear: assert property (p_ibf_clear) else $error("input full not cleared"); // see RULE_12

  property p_obf_set;
    output_buffer_write && !slave_read_start |=> output_buffer_full_flag;
  endproperty
  a_obf_set: assert property (p_obf_set) else $error("output full not set"); // see RULE_13

  property p_irq_pulse;
    !slave_write_end |=> !slave_port_irq_flag;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt flag without write end"); // see RULE_19

  property p_master_clear_input_off;
    !(master_clear_enable_cfg && !input_only_pin_3) |=> !master_clear_request;
  endproperty
  a_master_clear_input_off: assert property (p_master_clear_input_off) else $error("master clear raised wrongly"); // see RULE_07

  property p_pin3_shown;
    s_read_pin ##0 !master_clear_enable_cfg |=> wb_dat_o[port_e_pkg::BIT_PIN3] == $past(input_only_pin_3);
  endproperty
  a_pin3_shown: assert property (p_pin3_shown) else $error("pin three level not read"); // see RULE_08

  property p_latch_write;
    s_write_latch ##0 LARGE_PACKAGE |=> latch == $past(wb_dat_i[2:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost"); // see RULE_06

  property p_dir_write;
    s_write_dir ##0 LARGE_PACKAGE |=> dir == $past(wb_dat_i[2:0])
      && slave_port_mode_bit == $past(wb_dat_i[port_e_pkg::BIT_MODE]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost"); // see RULE_20

  property p_obf_ro;
    s_write_dir ##0 !output_buffer_write && !slave_read_start
      |=> output_buffer_full_flag == $past(output_buffer_full_flag);
  endproperty
  a_obf_ro: assert property (p_obf_ro) else $error("software changed output full"); // see RULE_20

endmodule : port_e_gpio

//--- dv/port_e_pin_model.sv
// Far-side circuitry on the three bidirectional pins
`timescale 1ns/100ps
module port_e_pin_model (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] ext_val,
  input  wire logic [2:0] ext_en,
  output logic      [2:0] pin_in
);
  // ----------------------------------------------------------------------
  // Wire level from both drivers
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe[i] && ext_en[i])
        pin_in[i] = 1'bx;
      else if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else
        pin_in[i] = ~pin_out[i];
    end
  end
endmodule : port_e_pin_model

//--- dv/port_e_gpio_with_direction_control_test.sv
// Self-checking bench for the general-purpose port
`timescale 1ns/100ps
module port_e_gpio_with_direction_control_test;
  logic clk_sys = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, analog_pin_config_field = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [2:0] pin_in, pin_out, pin_oe, analog_select = 3'h0, ext_val = 3'h0, ext_en = 3'h0;
  logic input_only_pin_3 = 0, master_clear_enable_cfg = 0, master_clear_request;
  logic slave_write_end = 0, slave_read_start = 0, input_buffer_read = 0, output_buffer_write = 0;
  logic slave_port_irq_flag, strobe_active, read_strobe_n, write_strobe_n, chip_select_n;
  logic [7:0] q;
  logic [14:0] rows [5] = '{15'h002A, 15'h2F42, 15'h5E17, 15'h25EA, 15'h5CC4};
  int n_fail = 0, check_count = 0;

  port_e_gpio uut (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .wb_dat_o, .pin_in, .pin_out, .pin_oe, .input_only_pin_3,
    .master_clear_enable_cfg, .master_clear_request, .analog_select, .analog_pin_config_field,
    .slave_write_end, .slave_read_start, .input_buffer_read, .output_buffer_write,
    .slave_port_irq_flag, .strobe_active, .read_strobe_n, .write_strobe_n, .chip_select_n);
  port_e_pin_model model (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

  always #4 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // Bus, compare, slave event pulse and closing tasks
  // ----------------------------------------------------------------------
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : check

  task wb(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, adr, sel};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    if (wb_ack_o !== 1'b1) check("ack", 8'h01, 8'h00);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : wb

  task rd(input string name, input logic [3:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 4'hF, 8'h00);
    check(name, exp, q);
  endtask : rd

  task pulse(input logic [3:0] v);
    @(posedge clk_sys);
    {slave_write_end, slave_read_start, input_buffer_read, output_buffer_write} <= v;
    @(posedge clk_sys);
    {slave_write_end, slave_read_start, input_buffer_read, output_buffer_write} <= 4'h0;
  endtask : pulse

  task final_report;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    final_report;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    check("oe_reset", 8'h00, {5'h0, pin_oe});
    reset_n <= 1'b1;
    rd("dir_reset", port_e_pkg::OFS_DIR, 8'h07);
    rd("latch_reset", port_e_pkg::OFS_LATCH, 8'h00);
    foreach (rows[i]) begin
      wb(1'b1, port_e_pkg::OFS_LATCH, 4'h1, {5'h0, rows[i][8:6]});
      wb(1'b1, port_e_pkg::OFS_DIR, 4'h1, {5'h0, rows[i][11:9]});
      analog_select <= rows[i][5:3];
      ext_val <= rows[i][2:0];
      ext_en <= rows[i][11:9];
      repeat (3) @(posedge clk_sys);
      check("oe", {5'h0, ~rows[i][11:9]}, {5'h0, pin_oe});
      check("out", {5'h0, rows[i][8:6]}, {5'h0, pin_out});
      rd("pins", port_e_pkg::OFS_PIN_DATA, {5'h0, rows[i][14:12]});
      rd("latch", port_e_pkg::OFS_LATCH, {5'h0, rows[i][8:6]});
    end
    analog_select <= 3'h7;
    for (int c = 0; c < 4; c++) begin
      master_clear_enable_cfg <= c[1];
      input_only_pin_3 <= c[0];
      repeat (3) @(posedge clk_sys);
      check("master_clear_input", {7'h0, c[1] & ~c[0]}, {7'h0, master_clear_request});
      rd("pin3", port_e_pkg::OFS_PIN_DATA, {4'h0, ~c[1] & c[0], 3'h0});
    end
    wb(1'b1, port_e_pkg::OFS_DIR, 4'h1, 8'h17);
    ext_en <= 3'h7;
    foreach (rows[i]) begin
      analog_pin_config_field <= 4'h9 + 4'(i % 3) * 4'h3;
      ext_val <= 3'(i);
      repeat (3) @(posedge clk_sys);
      check("strobe", (i % 3) ? {5'h02, 3'(i)} : 8'h07,
            {3'h0, strobe_active, 1'b0, chip_select_n, write_strobe_n, read_strobe_n});
    end
    wb(1'b1, port_e_pkg::OFS_DIR, 4'h1, 8'h07);
    pulse(4'h8);
    @(posedge clk_sys);
    check("irq", 8'h01, {7'h0, slave_port_irq_flag});
    @(posedge clk_sys);
    check("irq_end", 8'h00, {7'h0, slave_port_irq_flag});
    rd("ibf", port_e_pkg::OFS_DIR, 8'h87);
    pulse(4'h8);
    rd("input_overflow_flag", port_e_pkg::OFS_DIR, 8'hA7);
    wb(1'b1, port_e_pkg::OFS_DIR, 4'h1, 8'h47);
    rd("ro_flags", port_e_pkg::OFS_DIR, 8'h87);
    pulse(4'h2);
    rd("ibf_clr", port_e_pkg::OFS_DIR, 8'h07);
    pulse(4'h1);
    rd("obf", port_e_pkg::OFS_DIR, 8'h47);
    pulse(4'h4);
    rd("obf_clr", port_e_pkg::OFS_DIR, 8'h07);
    wb(1'b1, port_e_pkg::OFS_LATCH, 4'h2, 8'h07);
    rd("sel_ignored", port_e_pkg::OFS_LATCH, 8'h03);
    rd("unmapped", 4'hC, 8'h00);
    pulse(4'hA);
    rd("ibf_set_wins", port_e_pkg::OFS_DIR, 8'h87);
    pulse(4'h5);
    rd("obf_clear_wins", port_e_pkg::OFS_DIR, 8'h87);
    ext_en <= 3'h0;
    wb(1'b1, port_e_pkg::OFS_DIR, 4'h1, 8'h20);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("oe_rst2", 8'h00, {5'h0, pin_oe});
    check("out_rst2", 8'h00, {5'h0, pin_out});
    reset_n <= 1'b1;
    rd("dir_rst2", port_e_pkg::OFS_DIR, 8'h07);
    rd("latch_rst2", port_e_pkg::OFS_LATCH, 8'h00);
    final_report;
  end
endmodule : port_e_gpio_with_direction_control_test
